// >>> verilog/wlr_defs.svh
`ifndef WLR_DEFS_SVH
`define WLR_DEFS_SVH

// Register addresses
`define WLR_ADDR_STAT1      8'h02
`define WLR_ADDR_STAT2      8'h03
`define WLR_ADDR_TEMP       8'h0E
`define WLR_ADDR_LOCK       8'h10

// Reset values
`define WLR_LOCK_RESET      8'h00
`define WLR_TEMP_RESET      8'h00

// Lock control field positions
`define WLR_BIT_INIT        7
`define WLR_BIT_RPTOFF      3
`define WLR_KEY_MASK        8'h03

// Status field positions
`define WLR_STAT1_SUP_BIT   0
`define WLR_STAT2_RW_BIT    5

// Reset key steps, value of key field [1:0]
`define WLR_KEY_STEP1       2'h0
`define WLR_KEY_STEP2       2'h3
`define WLR_KEY_STEP3       2'h2

// Check code
`define WLR_CRC_POLY        8'h07
`define WLR_CRC_INIT        8'hFF

// Response latency in clock cycles
`define WLR_RESP_LAT        1

`endif

// >>> verilog/wlr_pkg.sv
package wlr_pkg;

  typedef enum logic [2:0] {
    KEY_IDLE   = 3'b001,
    KEY_ARMED  = 3'b010,
    KEY_PRIMED = 3'b100
  } wlr_key_e;

  typedef logic [7:0] wlr_byte_t;

endpackage

// >>> verilog/wlr_chk_code.sv
`timescale 1ns/1ps
`include "wlr_defs.svh"

module wlr_chk_code
  import wlr_pkg::*;
#(
  parameter int BYTES = 2
) (
  // Image in
  input  wire logic [BYTES*8-1:0] image,
  // Code out
  output wlr_byte_t               code
);

  initial begin
    if (BYTES < 1) begin
      $error("wlr_chk_code needs at least one byte");
    end
  end

  function automatic wlr_byte_t crc_step(input wlr_byte_t crc, input wlr_byte_t data);
    wlr_byte_t c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `WLR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  wlr_byte_t chain [BYTES+1];

  assign chain[0] = `WLR_CRC_INIT;

  genvar b;
  generate
    for (b = 0; b < BYTES; b++) begin : g_byte
      assign chain[b+1] = crc_step(chain[b], image[b*8 +: 8]);
    end
  endgenerate

  assign code = chain[BYTES];

endmodule

// >>> verilog/wlr_ctrl.sv
`timescale 1ns/1ps
`include "wlr_defs.svh"


module wlr_ctrl
  import wlr_pkg::*;
#(
  parameter int USER_BYTES = 1
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Register access
  input  wire logic                    regWrEn,
  input  wire logic                    regRdEn,
  input  wire logic [7:0]              regAddr,
  input  wire logic [7:0]              regWrData,
  // Response
  output logic                         respValid,
  output wlr_byte_t                    respData,
  output logic                         respErrCode,
  output logic                         respNoAck,
  // Other user registers
  output logic                         extWrEn,
  input  wire logic [USER_BYTES*8-1:0] userImage,
  // Temperature
  input  wire logic                    tempUpdate,
  input  wire logic [7:0]              tempValue,
  // Supply monitor
  input  wire logic                    spiMode,
  input  wire logic                    supFaultSet,
  input  wire logic                    supTimerZero,
  output logic                         supplyFault,
  output logic                         respHold,
  // Integrity
  output logic                         rwFault,
  // Self-test
  input  wire logic                    selfTestStart,
  input  wire logic                    selfTestDone,
  output logic                         selfTestActive,
  // Lock state
  output logic                         initDone,
  output logic                         reportOff,
  output logic                         softResetReq
);

  initial begin
    if (USER_BYTES < 1) begin
      $error("wlr_ctrl needs at least one user byte");
    end
  end

  wlr_byte_t lockReg;
  wlr_byte_t tempReg;
  wlr_byte_t storedCode;
  wlr_byte_t chkCode;
  wlr_byte_t rdMux;
  wlr_byte_t newLock;
  wlr_key_e  keyState;
  wlr_key_e  next_keyState;
  logic      codeValid;
  logic      fire;
  logic      coreRst;
  logic      taken;
  logic      wrLock;
  logic      rdStat1;
  logic      rdStat2;
  logic      errCodeDue;
  logic      errSend;
  logic      supClr;
  logic      mismatch;
  logic [1:0] keyWr;

  // Soft reset reuses the synchronous reset path one cycle after the fire
  assign coreRst    = !rst_n || softResetReq;
  assign taken      = regWrEn || regRdEn;
  assign wrLock     = regWrEn && !regRdEn && (regAddr == `WLR_ADDR_LOCK);
  assign rdStat1    = regRdEn && (regAddr == `WLR_ADDR_STAT1);
  assign rdStat2    = regRdEn && (regAddr == `WLR_ADDR_STAT2);
  assign keyWr      = regWrData[1:0];
  assign initDone   = lockReg[`WLR_BIT_INIT];
  assign reportOff  = lockReg[`WLR_BIT_RPTOFF];
  assign respHold   = supplyFault && !supTimerZero;
  assign errCodeDue = spiMode && !reportOff && supplyFault && supTimerZero;
  assign errSend    = taken && !respHold && !fire && errCodeDue;
  assign mismatch   = codeValid && (chkCode != storedCode);
  assign extWrEn    = regWrEn && !regRdEn && !initDone &&
                      (regAddr != `WLR_ADDR_LOCK) && (regAddr != `WLR_ADDR_TEMP);
  // Once locked only the key bits move
  assign newLock    = initDone ? {lockReg[7:2], keyWr} : regWrData;

  // Key sequence; a read always wins and aborts
  always_comb begin
    next_keyState = keyState;
    fire          = 1'b0;
    if (regRdEn) begin
      next_keyState = KEY_IDLE;
    end else if (regWrEn) begin
      if (regAddr != `WLR_ADDR_LOCK) begin
        next_keyState = KEY_IDLE;
      end else begin
        case (keyState)
          KEY_IDLE: begin
            next_keyState = (keyWr == `WLR_KEY_STEP1) ? KEY_ARMED : KEY_IDLE;
          end
          KEY_ARMED: begin
            if (keyWr == `WLR_KEY_STEP2) begin
              next_keyState = KEY_PRIMED;
            end else begin
              next_keyState = (keyWr == `WLR_KEY_STEP1) ? KEY_ARMED : KEY_IDLE;
            end
          end
          KEY_PRIMED: begin
            if (keyWr == `WLR_KEY_STEP3) begin
              fire          = 1'b1;
              next_keyState = KEY_IDLE;
            end else begin
              next_keyState = (keyWr == `WLR_KEY_STEP1) ? KEY_ARMED : KEY_IDLE;
            end
          end
          default: begin
            next_keyState = KEY_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      keyState <= KEY_IDLE;
    end else begin
      keyState <= next_keyState;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      softResetReq <= 1'b0;
    end else begin
      softResetReq <= fire && !softResetReq;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      lockReg <= `WLR_LOCK_RESET;
    end else if (wrLock) begin
      lockReg <= newLock;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      tempReg <= `WLR_TEMP_RESET;
    end else if (tempUpdate) begin
      tempReg <= tempValue;
    end
  end

  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      `WLR_ADDR_TEMP:  rdMux = tempReg;
      `WLR_ADDR_LOCK:  rdMux = lockReg & ~`WLR_KEY_MASK;
      `WLR_ADDR_STAT1: rdMux[`WLR_STAT1_SUP_BIT] = supplyFault;
      `WLR_ADDR_STAT2: rdMux[`WLR_STAT2_RW_BIT] = rwFault;
      default:         rdMux = 8'h00;
    endcase
  end

  // Held or firing accesses get neither data nor acknowledge
  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      respValid   <= 1'b0;
      respNoAck   <= 1'b0;
      respErrCode <= 1'b0;
      respData    <= 8'h00;
    end else begin
      respValid   <= taken && !respHold && !fire;
      respNoAck   <= taken && (respHold || fire);
      respErrCode <= errSend;
      if (regRdEn) begin
        respData <= rdMux;
      end else if (wrLock) begin
        respData <= newLock;
      end else if (extWrEn) begin
        respData <= regWrData;
      end else begin
        respData <= 8'h00;
      end
    end
  end

  always_comb begin
    if (spiMode && reportOff) begin
      supClr = supTimerZero;
    end else if (spiMode) begin
      supClr = (rdStat1 && supTimerZero) || errSend;
    end else begin
      supClr = rdStat1;
    end
  end

  // New fault beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      supplyFault <= 1'b0;
    end else begin
      supplyFault <= supFaultSet || (supplyFault && !supClr);
    end
  end

  wlr_chk_code #(
    .BYTES (USER_BYTES + 1)
  ) u_chk (
    .image ({userImage, lockReg & ~`WLR_KEY_MASK}),
    .code  (chkCode)
  );

  // Reference taken once the image is frozen by the lock
  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      codeValid  <= 1'b0;
      storedCode <= 8'h00;
    end else if (initDone && !codeValid) begin
      codeValid  <= 1'b1;
      storedCode <= chkCode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      rwFault <= 1'b0;
    end else begin
      rwFault <= mismatch || (rwFault && !rdStat2);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      selfTestActive <= 1'b0;
    end else begin
      selfTestActive <= !initDone &&
                        (selfTestStart || (selfTestActive && !selfTestDone));
    end
  end

  sequence s_key_wr(logic [1:0] k);
    wrLock && (keyWr == k);
  endsequence

  // One idle cycle between key writes, the host's usual spacing
  sequence s_valid_keys;
    s_key_wr(`WLR_KEY_STEP1) ##1 !taken ##1 s_key_wr(`WLR_KEY_STEP2) ##1 !taken
      ##1 s_key_wr(`WLR_KEY_STEP3);
  endsequence

  property p_temp_ro;
    @(posedge sys_clk) disable iff (coreRst)
    (regWrEn && regAddr == `WLR_ADDR_TEMP && !tempUpdate) |=> (tempReg == $past(tempReg));
  endproperty
  a_temp_ro: assert property (p_temp_ro) else $error("temperature changed on write");

  property p_lock_frozen;
    @(posedge sys_clk) disable iff (coreRst)
    (initDone && wrLock) |=> (lockReg[7:2] == $past(lockReg[7:2]));
  endproperty
  a_lock_frozen: assert property (p_lock_frozen) else $error("locked bits changed");

  property p_init_sticky;
    @(posedge sys_clk) disable iff (coreRst)
    initDone |=> initDone;
  endproperty
  a_init_sticky: assert property (p_init_sticky) else $error("init done cleared");

  property p_code_capture;
    @(posedge sys_clk) disable iff (coreRst)
    $rose(initDone) |=> codeValid && (storedCode == $past(chkCode));
  endproperty
  a_code_capture: assert property (p_code_capture) else $error("code not stored");

  property p_rw_fault;
    @(posedge sys_clk) disable iff (coreRst)
    (codeValid && chkCode != storedCode) |=> rwFault;
  endproperty
  a_rw_fault: assert property (p_rw_fault) else $error("mismatch not flagged");

  property p_selftest_off;
    @(posedge sys_clk) disable iff (coreRst)
    initDone |=> !selfTestActive;
  endproperty
  a_selftest_off: assert property (p_selftest_off) else $error("self-test ran locked");

  property p_err_once;
    @(posedge sys_clk) disable iff (coreRst)
    respErrCode |-> (!supplyFault || $past(supFaultSet)) ##1 !respErrCode;
  endproperty
  a_err_once: assert property (p_err_once) else $error("error code repeated");

  property p_hold;
    @(posedge sys_clk) disable iff (coreRst)
    (taken && respHold) |=> !respValid && respNoAck;
  endproperty
  a_hold: assert property (p_hold) else $error("response while timer runs");

  property p_auto_clear;
    @(posedge sys_clk) disable iff (coreRst)
    (spiMode && reportOff && supTimerZero && !supFaultSet) |=> !supplyFault;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("fault not self-cleared");

  property p_i2c_clear;
    @(posedge sys_clk) disable iff (coreRst)
    (!spiMode && rdStat1 && !supFaultSet) |=> !supplyFault;
  endproperty
  a_i2c_clear: assert property (p_i2c_clear) else $error("status read kept fault");

  property p_reset_seq;
    @(posedge sys_clk) disable iff (!rst_n)
    s_valid_keys |=> softResetReq && !respValid && respNoAck;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("key sequence ignored");

  property p_write_echo;
    @(posedge sys_clk) disable iff (coreRst)
    (wrLock && !respHold && !fire) |=> respValid && (respData[1:0] == $past(keyWr));
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("write echo wrong");

  property p_read_abort;
    @(posedge sys_clk) disable iff (coreRst)
    (regRdEn && regAddr == `WLR_ADDR_LOCK) |=>
      (keyState == KEY_IDLE) && (respData[1:0] == 2'h0) ##1 !softResetReq;
  endproperty
  a_read_abort: assert property (p_read_abort) else $error("read kept sequence");

  property p_key_excluded;
    @(posedge sys_clk) disable iff (coreRst)
    (wrLock && initDone) |=> (chkCode == $past(chkCode)) || (userImage != $past(userImage));
  endproperty
  a_key_excluded: assert property (p_key_excluded) else $error("key bits in code");

  property p_bad_key;
    @(posedge sys_clk) disable iff (coreRst)
    (keyState == KEY_PRIMED && wrLock && keyWr != `WLR_KEY_STEP3) |=> !softResetReq;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("reset on wrong key");

endmodule

// >>> tb/wlr_host.sv
`timescale 1ns/1ps

module wlr_host (
  // Clock
  input  wire logic       sys_clk,
  // Requests
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  // Answers
  input  wire logic       respValid,
  input  wire logic [7:0] respData,
  input  wire logic       respErrCode,
  input  wire logic       respNoAck,
  input  wire logic       extWrEn
);
  logic [7:0] lastData;
  logic       lastValid;
  logic       lastNoAck;
  logic       lastErr;
  logic       lastExt;

  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // One-cycle strobe, answer taken half a cycle after the accepting edge
  task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    regWrEn   = wr;
    regRdEn   = !wr;
    regAddr   = addr;
    regWrData = data;
    #1 lastExt = extWrEn;
    @(negedge sys_clk);
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    // Released lines must not keep showing the last value
    regAddr   = ~regAddr;
    regWrData = ~regWrData;
    lastData  = respData;
    lastValid = respValid;
    lastNoAck = respNoAck;
    lastErr   = respErrCode;
  endtask
endmodule

// >>> tb/test_write_lock_reset_control.sv
`timescale 1ns/1ps

module test_write_lock_reset_control;
  import wlr_pkg::*;
  logic       sys_clk, rst_n, regWrEn, regRdEn, respValid, respErrCode, respNoAck;
  logic       extWrEn, tempUpdate, spiMode, supFaultSet, supTimerZero, supplyFault;
  logic       respHold, rwFault, selfTestStart, selfTestDone, selfTestActive;
  logic       initDone, reportOff, softResetReq;
  logic [7:0] regAddr, regWrData, userImage, tempValue, r;
  wlr_byte_t  respData;
  int         error_cnt, comparisons, cycles, seed;

  wlr_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .respValid(respValid), .respData(respData),
    .respErrCode(respErrCode), .respNoAck(respNoAck), .extWrEn(extWrEn),
    .userImage(userImage), .tempUpdate(tempUpdate), .tempValue(tempValue),
    .spiMode(spiMode), .supFaultSet(supFaultSet), .supTimerZero(supTimerZero),
    .supplyFault(supplyFault), .respHold(respHold), .rwFault(rwFault),
    .selfTestStart(selfTestStart), .selfTestDone(selfTestDone),
    .selfTestActive(selfTestActive), .initDone(initDone), .reportOff(reportOff),
    .softResetReq(softResetReq));

  wlr_host host (.sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .respValid(respValid), .respData(respData),
    .respErrCode(respErrCode), .respNoAck(respNoAck), .extWrEn(extWrEn));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lockRead(input logic [7:0] d);
    return d & 8'hFC;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic complete_run;
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far above the length of the sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run;
    end
  end

  initial begin
    seed = 65092;
    {rst_n, tempUpdate, spiMode, supFaultSet, supTimerZero} = 5'b00000;
    {selfTestStart, selfTestDone, tempValue} = 10'h000;
    userImage = $random(seed);
    tick(5);
    rst_n = 1'b1;
    host.acc(0, 8'h0E, 8'h00); chk8(host.lastData, 8'h00);
    host.acc(0, 8'h10, 8'h00); chk8(host.lastData, 8'h00);
    r = $random(seed);
    tempValue = r;
    pulse(tempUpdate);
    host.acc(1, 8'h0E, ~r);
    host.acc(0, 8'h0E, 8'h00); chk8(host.lastData, r);
    repeat (6) begin
      tempValue = $random(seed) & 8'h7F;
      host.acc(1, 8'h10, tempValue); chk8(host.lastData, tempValue);
      host.acc(0, 8'h10, 8'h00); chk8(host.lastData, lockRead(tempValue));
    end
    tempValue = r;
    host.acc(1, 8'h20, 8'h5A); chk1(host.lastExt, 1'b1);
    // Sequences broken by a read and by a wrong key
    host.acc(1, 8'h10, 8'h00);
    host.acc(1, 8'h10, 8'h03);
    host.acc(0, 8'h10, 8'h00);
    host.acc(1, 8'h10, 8'h02); chk1(host.lastNoAck, 1'b0);
    host.acc(1, 8'h10, 8'h00);
    host.acc(1, 8'h10, 8'h01);
    host.acc(1, 8'h10, 8'h02); chk1(softResetReq, 1'b0);
    // Supply fault, I2C
    supFaultSet = 1'b1;
    tick(1);
    supFaultSet = 1'b0;
    host.acc(0, 8'h02, 8'h00); chk1(host.lastNoAck, 1'b1);
    tick(1); chk1(supplyFault, 1'b0);
    // Supply fault, SPI, reporting on
    spiMode = 1'b1;
    host.acc(1, 8'h10, 8'h00);
    pulse(supFaultSet);
    host.acc(0, 8'h02, 8'h00); chk1(host.lastNoAck, 1'b1);
    chk1(supplyFault, 1'b1);
    supTimerZero = 1'b1;
    host.acc(0, 8'h0E, 8'h00); chk1(host.lastErr, 1'b1);
    chk1(supplyFault, 1'b0);
    host.acc(0, 8'h0E, 8'h00); chk1(host.lastErr, 1'b0);
    // Supply fault, SPI, reporting off
    host.acc(1, 8'h10, 8'h08); chk1(reportOff, 1'b1);
    supTimerZero = 1'b0;
    pulse(supFaultSet);
    chk1(respHold, 1'b1);
    host.acc(0, 8'h0E, 8'h00); chk1(host.lastNoAck, 1'b1);
    supTimerZero = 1'b1;
    tick(2); chk1(supplyFault, 1'b0);
    host.acc(0, 8'h0E, 8'h00); chk1(host.lastValid, 1'b1);
    // Self-test, then the lock stops it
    pulse(selfTestStart);
    chk1(selfTestActive, 1'b1);
    pulse(selfTestDone);
    chk1(selfTestActive, 1'b0);
    pulse(selfTestStart);
    chk1(selfTestActive, 1'b1);
    host.acc(1, 8'h10, 8'h80);
    tick(2); chk1(selfTestActive, 1'b0);
    pulse(selfTestStart);
    chk1(selfTestActive, 1'b0);
    host.acc(1, 8'h10, 8'h00); chk8(host.lastData, 8'h80);
    chk1(initDone, 1'b1);
    host.acc(1, 8'h20, 8'hA5); chk1(host.lastExt, 1'b0);
    host.acc(1, 8'h0E, 8'h33);
    host.acc(1, 8'h10, 8'h03); chk8(host.lastData, 8'h83);
    tick(2); chk1(rwFault, 1'b0);
    host.acc(0, 8'h0E, 8'h00); chk8(host.lastData, r);
    userImage = ~userImage;
    tick(3); chk1(rwFault, 1'b1);
    host.acc(0, 8'h03, 8'h00); chk1(host.lastData[5], 1'b1);
    // Full key sequence resets the device
    host.acc(1, 8'h10, 8'h00);
    host.acc(1, 8'h10, 8'h03); chk8(host.lastData, 8'h83);
    host.acc(1, 8'h10, 8'h02); chk1(host.lastNoAck, 1'b1);
    chk1(host.lastValid, 1'b0);
    chk1(softResetReq, 1'b1);
    tick(1);
    host.acc(0, 8'h10, 8'h00); chk8(host.lastData, 8'h00);
    chk1(initDone, 1'b0);
    complete_run;
  end
endmodule
